/* src/output_frequency_ramp_generator.sv */
`default_nettype none
module output_frequency_ramp_generator
    import ramp_gen_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic [7:0]  bus_addr_in,
    input  wire logic [15:0] bus_wdata_in,
    input  wire logic        bus_wr_in,
    input  wire logic        bus_rd_in,
    output logic      [15:0] bus_rdata_out,
    input  wire logic [1:0]  time_sel_in,
    input  wire logic        jog_cmd_in,
    input  wire logic        emergency_halt_command_in,
    input  wire logic        stage_run_in,
    input  wire logic [1:0]  stage_set_in,
    output logic      [15:0] out_freq_out,
    output logic      [2:0]  ramp_state_out,
    output logic             coast_out
);
    if (TICK_CYCLES_P < 1 || TICK_CYCLES_P > 32'h00ff_ffff) begin : g_chk
        $error("TICK_CYCLES_P out of range");
    end

    bus_req_t    req;
    logic [1:0]  shape_r,  shape_nxt;
    logic [15:0] end_r,    end_nxt;
    logic [15:0] mid_r,    mid_nxt;
    ramp_pair_t  pair_r [4];
    ramp_pair_t  pair_nxt [4];
    logic [15:0] emer_t_r, emer_t_nxt;
    logic        style_r,  style_nxt;
    logic [15:0] top_r,    top_nxt;
    logic [15:0] run_r,    run_nxt;
    logic [15:0] jogf_r,   jogf_nxt;
    logic [15:0] rdata_r,  rdata_nxt;

    logic [3:0]  sync1_r, sync2_r;
    logic [1:0]  term_sel;
    logic        jog_s, emer_s;

    logic [1:0]  sel_set;
    logic [15:0] tgt, t_sel, up_t, down_t;
    logic        coast;
    ramp_state_t dir, state_r;
    logic [31:0] tick_len;
    logic [ACC_W-1:0] thr, acc_sum;
    logic [15:0] shape_f, w_used;
    logic        restart, tick, step;

    logic [15:0] freq_r, freq_nxt;
    logic [15:0] tgt_r, tsel_r;
    logic [31:0] tcnt_r, tcnt_nxt;
    logic [15:0] el_r, el_nxt;
    logic [ACC_W-1:0] acc_r, acc_nxt;
    logic [15:0] w_r, w_nxt;

    logic [DIV_W-1:0] t1000, lim_a, lim_m, lim_t, div_num, div_den, quot;
    logic        div_go, div_busy, div_done;

    assign req = '{wr: bus_wr_in, rd: bus_rd_in, addr: bus_addr_in, wdata: bus_wdata_in};

    // Register writes, with percentages and times clamped into range
    always_comb begin
        shape_nxt  = shape_r;
        end_nxt    = end_r;
        mid_nxt    = mid_r;
        pair_nxt   = pair_r;
        emer_t_nxt = emer_t_r;
        style_nxt  = style_r;
        top_nxt    = top_r;
        run_nxt    = run_r;
        jogf_nxt   = jogf_r;
        if (req.wr) begin
            case (req.addr)
                OFS_SHAPE:      shape_nxt  = req.wdata[1:0];
                OFS_END_PCT:    end_nxt    = clamp_range(req.wdata, END_PCT_MIN,
                                                         PCT_FULL - mid_r);
                OFS_MID_PCT:    mid_nxt    = clamp_range(req.wdata, MID_PCT_MIN,
                                                         PCT_FULL - end_r);
                OFS_EMER_TIME:  emer_t_nxt = clamp_range(req.wdata, TIME_MIN, TIME_MAX);
                OFS_EMER_STYLE: style_nxt  = req.wdata[0];
                OFS_TOP_FREQ:   top_nxt    = clamp_range(req.wdata, TOP_FREQ_MIN, 16'hffff);
                OFS_RUN_TARGET: run_nxt    = req.wdata;
                OFS_JOG_FREQ:   jogf_nxt   = req.wdata;
                default: ;
            endcase
            for (int j = 0; j < 4; j++) begin
                if (req.addr == 8'(OFS_TIME_BASE + 8'(j) * OFS_PAIR_STRIDE)) begin
                    pair_nxt[j].up = clamp_range(req.wdata, TIME_MIN, TIME_MAX);
                end
                if (req.addr == 8'(OFS_TIME_BASE + 8'(j) * OFS_PAIR_STRIDE
                                   + OFS_DOWN_OFFSET)) begin
                    pair_nxt[j].down = clamp_range(req.wdata, TIME_MIN, TIME_MAX);
                end
            end
        end
    end

    // Read data stands in the cycle after the strobe only; unmapped reads zero
    always_comb begin
        rdata_nxt = '0;
        if (req.rd) begin
            case (req.addr)
                OFS_SHAPE:      rdata_nxt = {14'h0, shape_r};
                OFS_END_PCT:    rdata_nxt = end_r;
                OFS_MID_PCT:    rdata_nxt = mid_r;
                OFS_EMER_TIME:  rdata_nxt = emer_t_r;
                OFS_EMER_STYLE: rdata_nxt = {15'h0, style_r};
                OFS_TOP_FREQ:   rdata_nxt = top_r;
                OFS_RUN_TARGET: rdata_nxt = run_r;
                OFS_JOG_FREQ:   rdata_nxt = jogf_r;
                OFS_OUT_FREQ:   rdata_nxt = freq_r;
                OFS_STATUS:     rdata_nxt = {8'h0, state_r, sel_set, jog_s, emer_s, coast};
                default: ;
            endcase
            for (int j = 0; j < 4; j++) begin
                if (req.addr == 8'(OFS_TIME_BASE + 8'(j) * OFS_PAIR_STRIDE)) begin
                    rdata_nxt = pair_r[j].up;
                end
                if (req.addr == 8'(OFS_TIME_BASE + 8'(j) * OFS_PAIR_STRIDE
                                   + OFS_DOWN_OFFSET)) begin
                    rdata_nxt = pair_r[j].down;
                end
            end
        end
    end

    // Ramp selection: jog beats emergency beats normal run
    always_comb begin
        sel_set = stage_run_in ? stage_set_in : term_sel;
        if (jog_s) begin
            sel_set = JOG_SET;
        end
        up_t   = pair_r[sel_set].up;
        down_t = pair_r[sel_set].down;
        coast  = 1'b0;
        if (jog_s) begin
            tgt = jogf_r;
        end else if (emer_s) begin
            tgt   = '0;
            coast = style_r;
            if (!style_r) begin
                down_t = emer_t_r;
            end
        end else begin
            tgt = run_r;
        end
        if (tgt > top_r) begin
            tgt = top_r;
        end
        if (freq_r < tgt) begin
            dir = ST_UP;
        end else if (freq_r > tgt) begin
            dir = ST_DOWN;
        end else begin
            dir = ST_IDLE;
        end
        t_sel = (dir == ST_UP) ? up_t : down_t;
    end

    // One time count lasts 0.01 s, or sixty times that in minute unit
    always_comb begin
        tick_len = shape_r[UNIT_BIT] ? 32'(TICK_CYCLES_P) * MIN_PER_UNIT
                                     : 32'(TICK_CYCLES_P);
        // Average S weight is (1000+mid)/2000 of peak, so the ramp time still holds
        shape_f  = shape_r[SHAPE_BIT] ? 16'(PCT_FULL + mid_r) : W_PEAK;
        w_used   = shape_r[SHAPE_BIT] ? w_r : W_PEAK;
        thr      = ACC_W'(t_sel) * ACC_W'(tick_len) * ACC_W'(shape_f);
        restart  = (tgt != tgt_r) || (t_sel != tsel_r) || (dir != state_r);
        tick     = (tcnt_r == tick_len - 32'h1);
        acc_sum  = acc_r + ACC_W'(top_r) * ACC_W'(w_used);
        step     = (dir != ST_IDLE) && !restart && (acc_sum >= thr);
    end

    // Frequency stepping, accumulator and elapsed time
    always_comb begin
        freq_nxt = freq_r;
        acc_nxt  = '0;
        tcnt_nxt = tick ? '0 : tcnt_r + 32'h1;
        el_nxt   = (tick && el_r != 16'hffff) ? el_r + 16'h1 : el_r;
        if (coast) begin
            freq_nxt = '0;
        end else if (step) begin
            // One count per clock can never pass the target
            freq_nxt = (dir == ST_UP) ? freq_r + 16'h1 : freq_r - 16'h1;
            acc_nxt  = acc_sum - thr;
        end else if (dir != ST_IDLE && !restart) begin
            acc_nxt = acc_sum;
        end
        if (restart) begin
            tcnt_nxt = '0;
            el_nxt   = '0;
        end
    end

    // S weight: rises over end segment, holds over mid, falls over the rest
    always_comb begin
        t1000   = DIV_W'(el_r) * DIV_W'(PCT_FULL);
        lim_a   = DIV_W'(t_sel) * DIV_W'(end_r);
        lim_m   = DIV_W'(t_sel) * DIV_W'(16'(end_r + mid_r));
        lim_t   = DIV_W'(t_sel) * DIV_W'(PCT_FULL);
        div_num = '0;
        div_den = '0;
        div_go  = 1'b0;
        w_nxt   = w_r;
        if (restart) begin
            w_nxt = W_FLOOR;
        end else if (div_done) begin
            w_nxt = (quot > DIV_W'(W_PEAK)) ? W_PEAK :
                    (quot < DIV_W'(W_FLOOR)) ? W_FLOOR : quot[15:0];
        end else if (tick && shape_r[SHAPE_BIT] && !div_busy) begin
            if (t1000 < lim_a) begin
                div_num = DIV_W'(W_PEAK) * t1000;
                div_den = lim_a;
                div_go  = 1'b1;
            end else if (t1000 < lim_m) begin
                w_nxt = W_PEAK;
            end else if (t1000 < lim_t) begin
                div_num = DIV_W'(W_PEAK) * (lim_t - t1000);
                div_den = lim_t - lim_m;
                div_go  = 1'b1;
            end else begin
                w_nxt = W_FLOOR;
            end
        end
    end

    ramp_step_divider #(
        .WIDTH (DIV_W)
    ) u_div (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .start_in   (div_go),
        .num_in     (div_num),
        .den_in     (div_den),
        .busy_out   (div_busy),
        .done_out   (div_done),
        .quot_out   (quot)
    );

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            shape_r  <= SHAPE_RST;
            end_r    <= END_PCT_RST;
            mid_r    <= MID_PCT_RST;
            for (int j = 0; j < 4; j++) begin
                pair_r[j] <= '{up: TIME_RST, down: TIME_RST};
            end
            emer_t_r <= TIME_RST;
            style_r  <= EMER_STYLE_RST;
            top_r    <= TOP_FREQ_RST;
            run_r    <= RUN_TARGET_RST;
            jogf_r   <= JOG_FREQ_RST;
            rdata_r  <= '0;
            sync1_r  <= '0;
            sync2_r  <= '0;
            freq_r   <= '0;
            tgt_r    <= '0;
            tsel_r   <= '0;
            state_r  <= ST_IDLE;
            tcnt_r   <= '0;
            el_r     <= '0;
            acc_r    <= '0;
            w_r      <= W_FLOOR;
        end else begin
            shape_r  <= shape_nxt;
            end_r    <= end_nxt;
            mid_r    <= mid_nxt;
            pair_r   <= pair_nxt;
            emer_t_r <= emer_t_nxt;
            style_r  <= style_nxt;
            top_r    <= top_nxt;
            run_r    <= run_nxt;
            jogf_r   <= jogf_nxt;
            rdata_r  <= rdata_nxt;
            sync1_r  <= {emergency_halt_command_in, jog_cmd_in, time_sel_in};
            sync2_r  <= sync1_r;
            freq_r   <= freq_nxt;
            tgt_r    <= tgt;
            tsel_r   <= t_sel;
            state_r  <= dir;
            tcnt_r   <= tcnt_nxt;
            el_r     <= el_nxt;
            acc_r    <= acc_nxt;
            w_r      <= w_nxt;
        end
    end

    assign term_sel       = sync2_r[1:0];
    assign jog_s          = sync2_r[2];
    assign emer_s         = sync2_r[3];
    assign bus_rdata_out  = rdata_r;
    assign out_freq_out   = freq_r;
    assign ramp_state_out = state_r;
    assign coast_out      = coast;

    a_lin_full_weight: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !shape_r[SHAPE_BIT] |-> (w_used == W_PEAK && shape_f == W_PEAK))
        else $error("linear ramp not at constant rate");
    a_s_weight_bound: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        shape_r[SHAPE_BIT] |-> (w_used >= W_FLOOR && w_used <= W_PEAK))
        else $error("S weight out of bounds");
    a_unit_tick_len: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        tick |-> (tcnt_r + 32'h1 == (shape_r[UNIT_BIT] ? 32'(TICK_CYCLES_P) * MIN_PER_UNIT
                                                        : 32'(TICK_CYCLES_P))))
        else $error("tick length ignores time unit");
    a_pct_in_range: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        end_r >= END_PCT_MIN && mid_r >= MID_PCT_MIN && 16'(end_r + mid_r) <= PCT_FULL)
        else $error("segment percentages out of range");
    a_step_one_count: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ##1 !$past(coast) |-> (freq_r == $past(freq_r) || freq_r == $past(freq_r) + 16'h1
                               || freq_r == $past(freq_r) - 16'h1))
        else $error("frequency jumped more than one count");
    a_no_overshoot: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (dir == ST_UP && !coast) |=> freq_r <= $past(tgt))
        else $error("ramp passed its target");
    a_pair_select: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !jog_s |-> sel_set == (stage_run_in ? stage_set_in : term_sel))
        else $error("wrong time pair selected");
    a_jog_priority: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        jog_s |-> (sel_set == JOG_SET && !coast && (tgt == jogf_r || tgt == top_r)))
        else $error("jog not given priority");
    a_emer_decel: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (emer_s && !jog_s && !style_r && dir == ST_DOWN) |-> t_sel == emer_t_r)
        else $error("emergency time not applied");
    a_emer_coast: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (emer_s && !jog_s && style_r) |=> freq_r == 16'h0)
        else $error("coast stop did not cut output");

    c_jog_ramp:   cover property (@(posedge clk_sys_in) disable iff (rst_in)
        jog_s && step);
    c_emer_decel: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        emer_s && !style_r && step && dir == ST_DOWN);
    c_s_mid:      cover property (@(posedge clk_sys_in) disable iff (rst_in)
        shape_r[SHAPE_BIT] && w_r == W_PEAK && step);
    c_min_unit:   cover property (@(posedge clk_sys_in) disable iff (rst_in)
        shape_r[UNIT_BIT] && tick);

endmodule : output_frequency_ramp_generator
`default_nettype wire

/* src/ramp_gen_pkg.sv */
`default_nettype none
package ramp_gen_pkg;

    localparam int          DATA_W          = 16;
    localparam int          ADDR_W          = 8;
    localparam int          DIV_W           = 40;
    localparam int          ACC_W           = 64;

    // Register byte offsets
    localparam logic [7:0]  OFS_SHAPE       = 8'h00;
    localparam logic [7:0]  OFS_END_PCT     = 8'h04;
    localparam logic [7:0]  OFS_MID_PCT     = 8'h08;
    localparam logic [7:0]  OFS_TIME_BASE   = 8'h0c;
    localparam logic [7:0]  OFS_PAIR_STRIDE = 8'h08;
    localparam logic [7:0]  OFS_DOWN_OFFSET = 8'h04;
    localparam logic [7:0]  OFS_EMER_TIME   = 8'h2c;
    localparam logic [7:0]  OFS_EMER_STYLE  = 8'h30;
    localparam logic [7:0]  OFS_TOP_FREQ    = 8'h34;
    localparam logic [7:0]  OFS_RUN_TARGET  = 8'h38;
    localparam logic [7:0]  OFS_JOG_FREQ    = 8'h3c;
    localparam logic [7:0]  OFS_OUT_FREQ    = 8'h40;
    localparam logic [7:0]  OFS_STATUS      = 8'h44;

    // Field positions of the ramp configuration
    localparam int          SHAPE_BIT       = 0;
    localparam int          UNIT_BIT        = 1;

    // Reset values (percent in tenths, times in hundredths, frequency in 0.01 Hz)
    localparam logic [1:0]  SHAPE_RST       = 2'h0;
    localparam logic [15:0] END_PCT_RST     = 16'h0096;
    localparam logic [15:0] MID_PCT_RST     = 16'h02bc;
    localparam logic [15:0] TIME_RST        = 16'h03e8;
    localparam logic [15:0] TOP_FREQ_RST    = 16'h1388;
    localparam logic [15:0] RUN_TARGET_RST  = 16'h0000;
    localparam logic [15:0] JOG_FREQ_RST    = 16'h01f4;
    localparam logic        EMER_STYLE_RST  = 1'b0;

    // Setting limits
    localparam logic [15:0] END_PCT_MIN     = 16'h0032;
    localparam logic [15:0] MID_PCT_MIN     = 16'h00c8;
    localparam logic [15:0] PCT_FULL        = 16'h03e8;
    localparam logic [15:0] TIME_MIN        = 16'h0001;
    localparam logic [15:0] TIME_MAX        = 16'hea60;
    localparam logic [15:0] TOP_FREQ_MIN    = 16'h0001;

    // Timing: one ramp-time count is 0.01 s, or 0.01 min in minute unit
    localparam int          CLK_PERIOD_NS   = 40;
    localparam int          TIME_LSB_NS     = 10_000_000;
    localparam int          TICK_CYCLES     = TIME_LSB_NS / CLK_PERIOD_NS;
    localparam logic [31:0] MIN_PER_UNIT    = 32'h0000_003c;

    // Rate weights for the S profile
    localparam logic [15:0] W_PEAK          = 16'h07d0;
    localparam logic [15:0] W_FLOOR         = 16'h007d;

    localparam logic [1:0]  JOG_SET         = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_UP   = 3'b010,
        ST_DOWN = 3'b100
    } ramp_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic [15:0] up;
        logic [15:0] down;
    } ramp_pair_t;

    function automatic logic [15:0] clamp_range(input logic [15:0] v,
                                                input logic [15:0] lo,
                                                input logic [15:0] hi);
        clamp_range = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp_range

endpackage : ramp_gen_pkg
`default_nettype wire

/* src/ramp_step_divider.sv */
`default_nettype none
module ramp_step_divider
    import ramp_gen_pkg::*;
#(
    parameter int unsigned WIDTH = DIV_W
) (
    input  wire logic             clk_sys_in,
    input  wire logic             rst_in,
    input  wire logic             start_in,
    input  wire logic [WIDTH-1:0] num_in,
    input  wire logic [WIDTH-1:0] den_in,
    output logic                  busy_out,
    output logic                  done_out,
    output logic      [WIDTH-1:0] quot_out
);
    localparam int CNT_W = $clog2(WIDTH + 1);

    if (WIDTH < 2) begin : g_chk
        $error("ramp_step_divider: WIDTH too small");
    end

    logic [WIDTH-1:0] rem_r,  rem_nxt;
    logic [WIDTH-1:0] quo_r,  quo_nxt;
    logic [WIDTH-1:0] den_r,  den_nxt;
    logic [CNT_W-1:0] cnt_r,  cnt_nxt;
    logic             busy_r, busy_nxt;
    logic             done_r, done_nxt;
    logic [WIDTH:0]   shifted;

    // Restoring division, one quotient bit per clock
    always_comb begin
        rem_nxt  = rem_r;
        quo_nxt  = quo_r;
        den_nxt  = den_r;
        cnt_nxt  = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        shifted  = {rem_r, quo_r[WIDTH-1]};
        if (start_in && !busy_r) begin
            rem_nxt  = '0;
            quo_nxt  = num_in;
            den_nxt  = den_in;
            cnt_nxt  = CNT_W'(WIDTH);
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            quo_nxt = {quo_r[WIDTH-2:0], 1'b0};
            if (shifted >= {1'b0, den_r}) begin
                rem_nxt    = WIDTH'(shifted - {1'b0, den_r});
                quo_nxt[0] = 1'b1;
            end else begin
                rem_nxt = shifted[WIDTH-1:0];
            end
            cnt_nxt = cnt_r - CNT_W'(1);
            if (cnt_r == CNT_W'(1)) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rem_r  <= '0;
            quo_r  <= '0;
            den_r  <= '0;
            cnt_r  <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            rem_r  <= rem_nxt;
            quo_r  <= quo_nxt;
            den_r  <= den_nxt;
            cnt_r  <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    // A zero divisor yields all ones, which the caller treats as saturation
    assign busy_out = busy_r;
    assign done_out = done_r;
    assign quot_out = quo_r;

endmodule : ramp_step_divider
`default_nettype wire

/* verification/drive_side_model.sv */
`default_nettype none
module drive_side_model
    import ramp_gen_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic [15:0] freq_in,
    output logic             step_err_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] last_r;
    initial begin
        step_err_out = 1'b0;
        last_r       = 16'h0;
    end
    // The power stage cannot follow jumps; a drop to zero is a coast, so it is let through
    always @(posedge clk_sys_in) begin
        if (freq_in != 16'h0 && (freq_in > last_r + 16'h1 || last_r > freq_in + 16'h1))
            step_err_out <= 1'b1;
        last_r <= freq_in;
    end
endmodule : drive_side_model
`default_nettype wire

/* verification/output_frequency_ramp_generator_tb.sv */
`default_nettype none
module output_frequency_ramp_generator_tb
    import ramp_gen_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [7:0]  addr = 8'h0;
    logic [15:0] wdata = 16'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [1:0]  sel = 2'h0;
    logic        jog = 1'b0;
    logic        emg = 1'b0;
    logic        srun = 1'b0;
    logic [1:0]  sset = 2'h0;
    logic [15:0] rdata;
    logic [15:0] out_freq_out;
    logic [2:0]  ramp_state_out;
    logic        coast_out;
    logic        step_err;
    int          errors = 0;
    int          checked = 0;
    logic [7:0]  ra [15] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
                             8'h20, 8'h24, 8'h28, 8'h2c, 8'h34, 8'h3c, 8'h50};
    logic [15:0] rv [15] = '{16'h0, 16'h0096, 16'h02bc, 16'h03e8, 16'h03e8, 16'h03e8,
                             16'h03e8, 16'h03e8, 16'h03e8, 16'h03e8, 16'h03e8, 16'h03e8,
                             16'h1388, 16'h01f4, 16'h0};
    output_frequency_ramp_generator #(.TICK_CYCLES_P(4)) dut (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus_addr_in(addr), .bus_wdata_in(wdata),
        .bus_wr_in(wr), .bus_rd_in(rd), .bus_rdata_out(rdata), .time_sel_in(sel),
        .jog_cmd_in(jog), .emergency_halt_command_in(emg), .stage_run_in(srun),
        .stage_set_in(sset), .out_freq_out(out_freq_out), .ramp_state_out(ramp_state_out),
        .coast_out(coast_out));
    drive_side_model side (.clk_sys_in(clk_sys_in), .freq_in(out_freq_out),
                           .step_err_out(step_err));
    initial begin
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys_in);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] m);
        @(posedge clk_sys_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        #1;
        check("read data", rdata & m, exp);
    endtask : rd_reg
    // Counts cycles until the output lands on the target; the window allows the restart cycles
    task automatic ramp(input logic [15:0] tgt, input int lo, input int hi);
        int n;
        n = 0;
        while (out_freq_out !== tgt && n < 2000) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        check("ramp cycles", {15'h0, n >= lo && n <= hi}, 16'h1);
        check("out freq", out_freq_out, tgt);
    endtask : ramp
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    initial begin
        #800000;
        errors++;
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 15; i++) rd_reg(ra[i], rv[i], 16'hffff);
        rd_reg(8'h44, 16'h0020, 16'hffff);
        $display("reset values done");
        wr_reg(8'h04, 16'd1000);
        rd_reg(8'h04, 16'd300, 16'hffff);
        wr_reg(8'h08, 16'd10);
        rd_reg(8'h08, 16'd200, 16'hffff);
        wr_reg(8'h04, 16'd0);
        rd_reg(8'h04, 16'd50, 16'hffff);
        wr_reg(8'h0c, 16'hffff);
        rd_reg(8'h0c, 16'hea60, 16'hffff);
        $display("clamp done");
        wr_reg(8'h34, 16'd100);
        wr_reg(8'h0c, 16'd100);
        wr_reg(8'h18, 16'd200);
        wr_reg(8'h24, 16'd100);
        wr_reg(8'h2c, 16'd100);
        wr_reg(8'h3c, 16'd80);
        wr_reg(8'h38, 16'd50);
        ramp(16'd50, 190, 215);
        sel <= 2'h1;
        wr_reg(8'h38, 16'd0);
        ramp(16'd0, 390, 415);
        rd_reg(8'h44, 16'h0008, 16'h0018);
        srun <= 1'b1;
        sset <= 2'h2;
        rd_reg(8'h44, 16'h0010, 16'h0018);
        srun <= 1'b0;
        sel <= 2'h0;
        $display("linear and selection done");
        wr_reg(8'h00, 16'h0002);
        wr_reg(8'h0c, 16'd1);
        wr_reg(8'h38, 16'd25);
        ramp(16'd25, 55, 75);
        wr_reg(8'h00, 16'h0000);
        wr_reg(8'h38, 16'd50);
        ramp(16'd50, 20, 35);
        emg <= 1'b1;
        ramp(16'd0, 190, 220);
        jog <= 1'b1;
        ramp(16'd80, 310, 340);
        jog <= 1'b0;
        wr_reg(8'h30, 16'h0001);
        repeat (3) @(posedge clk_sys_in);
        #1;
        check("coast", {15'h0, coast_out}, 16'h1);
        check("coast freq", out_freq_out, 16'h0);
        // Park the run target so the S ramp below starts from standstill
        wr_reg(8'h38, 16'd0);
        emg <= 1'b0;
        wr_reg(8'h30, 16'h0000);
        $display("jog and emergency done");
        wr_reg(8'h0c, 16'd100);
        wr_reg(8'h08, 16'd700);
        wr_reg(8'h04, 16'd150);
        wr_reg(8'h00, 16'h0001);
        wr_reg(8'h38, 16'd50);
        ramp(16'd50, 200, 320);
        check("step size", {15'h0, step_err}, 16'h0);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        #1;
        check("freq after reset", out_freq_out, 16'h0);
        check("state after reset", {13'h0, ramp_state_out}, 16'h0001);
        check("coast after reset", {15'h0, coast_out}, 16'h0);
        rd_reg(8'h04, 16'h0096, 16'hffff);
        $display("s profile and reset done");
        end_of_test();
    end
endmodule : output_frequency_ramp_generator_tb
`default_nettype wire
